// *** test/lbx_exec_test.sv ***
/*
 * Self-checking bench for the execution unit: host port tasks, one-shot
 * instruction issue and expected values worked out by hand from the encoding.
 * Assumes the unit answers one cycle after each strobe or instruction.
 */

`timescale 1ns/10ps

module lbx_exec_test
    import lbx_pkg::*;
;

    logic        ref_clk;
    logic        reset_n;
    logic        instr_valid;
    logic [31:0] instr_word;
    logic [4:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic [31:0] fetch_addr;
    logic [3:0]  flags;
    logic        exec_done;
    logic        redirect;
    int          failures;
    int          tests_run;
    logic [31:0] pc_e;
    logic [31:0] ret;

    // Second operand Rm=r2 with bits 11:7 count, 6:5 type; last entry uses r8 as count
    localparam logic [11:0] SH_OP [8] = '{12'h202, 12'h222, 12'h242, 12'h462,
                                          12'h062, 12'hf82, 12'h042, 12'h832};
    localparam logic [31:0] SH_EXP [8] = '{32'hff000ff0, 32'h08ff000f, 32'hf8ff000f,
                                           32'hff8ff000, 32'hc7f8007f, 32'h80000000,
                                           32'hffffffff, 32'h00000000};

    // 200 MHz clock
    always #2.5 ref_clk = ~ref_clk;

    lbx_exec i_dut
    (
        .ref_clk     (ref_clk),
        .reset_n     (reset_n),
        .instr_valid (instr_valid),
        .instr_word  (instr_word),
        .reg_addr    (reg_addr),
        .reg_wdata   (reg_wdata),
        .reg_wr      (reg_wr),
        .reg_rd      (reg_rd),
        .reg_rdata   (reg_rdata),
        .fetch_addr  (fetch_addr),
        .flags       (flags),
        .exec_done   (exec_done),
        .redirect    (redirect)
    );

    lbx_imem i_mem
    (
        .fetch_addr (fetch_addr),
        .instr_word (instr_word)
    );

    function automatic logic [31:0] dp(input logic [3:0] c, input logic i,
        input logic [3:0] opc, input logic s, input logic [3:0] rn, input logic [3:0] rd,
        input logic [11:0] op2);
        return {c, 2'b00, i, opc, s, rn, rd, op2};
    endfunction : dp

    function automatic logic [31:0] br(input logic [3:0] c, input logic lnk,
        input logic [23:0] off);
        return {c, 3'b101, lnk, off};
    endfunction : br

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : summarize

    // Host write: one strobe cycle, then released
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask : wr

    // Host read: data is looked at only in the cycle after the strobe
    task automatic rd(input logic [4:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        @(negedge ref_clk);
        check("reg_rdata", exp, reg_rdata);
    endtask : rd

    // Place one word at the fetch address, issue it, check the one-cycle answer
    task automatic run(input logic [31:0] word, input logic [31:0] nxt, input logic redir);
        i_mem.mem[pc_e[9:2]] = word;
        @(posedge ref_clk);
        instr_valid <= 1'b1;
        @(posedge ref_clk);
        instr_valid <= 1'b0;
        @(negedge ref_clk);
        check("exec_done", 32'h1, {31'h0, exec_done});
        check("redirect", {31'h0, redir}, {31'h0, redirect});
        check("fetch_addr", nxt, fetch_addr);
        pc_e = nxt;
    endtask : run

    // Hang guard: far above the run length
    initial
    begin
        #100000;
        failures++;
        $display("Error watchdog expected finish seen hang");
        summarize();
    end

    initial
    begin
        ref_clk = 1'b0;
        reset_n = 1'b0;
        instr_valid = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 5'h00;
        reg_wdata = 32'h00000000;
        failures = 0;
        tests_run = 0;
        pc_e = 32'h00000000;
        ret = 32'h00000000;
        repeat (4) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(negedge ref_clk);
        check("fetch_addr", 32'h00000000, fetch_addr);
        check("flags", 32'h0, {28'h0, flags});
        rd(5'h03, 32'h00000000);
        wr(5'h14, 32'h12345678);
        rd(5'h14, 32'h00000000);
        $display("test reset done");

        // Operands for the logic tests; V preset to show it is kept
        wr(5'h01, 32'hf0f08001);
        wr(5'h02, 32'h8ff000ff);
        wr(5'h07, 32'hffffffff);
        wr(5'h08, 32'h00000020);
        wr(5'h0a, 32'h00000100);
        wr(STATUS_ADDR, 32'h00000001);
        run(dp(COND_AL, 1'b0, OPC_AND, 1'b1, 4'h1, 4'h3, 12'h002), pc_e + 4, 1'b0);
        rd(5'h03, 32'h80f00001);
        check("flags", 32'hb, {28'h0, flags});
        run(dp(COND_AL, 1'b1, OPC_AND, 1'b0, 4'h7, 4'h4, 12'hef0), pc_e + 4, 1'b0);
        rd(5'h04, 32'h00000f00);
        check("flags", 32'hb, {28'h0, flags});
        run(dp(COND_AL, 1'b0, OPC_BIC, 1'b1, 4'h1, 4'h5, 12'h002), pc_e + 4, 1'b0);
        rd(5'h05, 32'h70008000);
        check("flags", 32'h3, {28'h0, flags});
        run(dp(COND_AL, 1'b0, OPC_BIC, 1'b1, 4'h1, 4'h6, 12'h001), pc_e + 4, 1'b0);
        rd(5'h06, 32'h00000000);
        check("flags", 32'h7, {28'h0, flags});
        $display("test logic done");

        // Every shift type, boundary counts, and a register-held count of 32
        for (int k = 0; k < 8; k++)
        begin
            run(dp(COND_AL, 1'b0, OPC_AND, 1'b0, 4'h7, 4'hb, SH_OP[k]), pc_e + 4, 1'b0);
            rd(5'h0b, SH_EXP[k]);
        end
        $display("test shift done");

        // Never and a false not-equal (Z set) both just advance
        run(dp(COND_NV, 1'b0, OPC_AND, 1'b1, 4'h7, 4'hc, 12'h007), pc_e + 4, 1'b0);
        run(dp(4'h1, 1'b0, OPC_AND, 1'b1, 4'h7, 4'hc, 12'h007), pc_e + 4, 1'b0);
        rd(5'h0c, 32'h00000000);
        check("flags", 32'h7, {28'h0, flags});
        $display("test condition done");

        // Forward and backward branches, counted in words from address plus 8
        run(br(COND_AL, 1'b0, 24'h000003), pc_e + 20, 1'b1);
        run(br(COND_AL, 1'b0, 24'hfffffe), pc_e, 1'b1);
        check("flags", 32'h7, {28'h0, flags});
        wr(STATUS_ADDR, 32'h00000005);
        ret = 32'h50000000 | (pc_e + 4);
        run(br(COND_AL, 1'b1, 24'h000001), pc_e + 12, 1'b1);
        rd({1'b0, LINK_IDX}, ret);
        check("flags", 32'h5, {28'h0, flags});
        $display("test branch done");

        // Return by move: status kept without the set bit, restored with it
        wr(STATUS_ADDR, 32'h00000000);
        run(dp(COND_AL, 1'b0, OPC_MOV, 1'b0, 4'h0, PC_IDX, 12'h00e), ret & 32'h0ffffffc,
            1'b1);
        check("flags", 32'h0, {28'h0, flags});
        run(dp(COND_AL, 1'b0, OPC_MOV, 1'b1, 4'h0, PC_IDX, 12'h00e), ret & 32'h0ffffffc,
            1'b1);
        check("flags", 32'h5, {28'h0, flags});
        // Bit clear into the PC jumps but leaves status alone even with S
        run(dp(COND_AL, 1'b1, OPC_BIC, 1'b1, 4'ha, PC_IDX, 12'h000), 32'h00000100,
            1'b1);
        check("flags", 32'h5, {28'h0, flags});
        // PC as operand, top nibble masked off
        run(dp(COND_AL, 1'b1, OPC_BIC, 1'b0, PC_IDX, 4'h9, 12'h4f0), pc_e + 4, 1'b0);
        rd(5'h09, 32'h00000108);
        // OR into the PC jumps with status kept; the status write op loads it
        run(dp(COND_AL, 1'b1, OPC_ORR, 1'b1, 4'ha, PC_IDX, 12'h008), 32'h00000108,
            1'b1);
        check("flags", 32'h5, {28'h0, flags});
        run(dp(COND_AL, 1'b1, OPC_TEQ, 1'b1, 4'h7, PC_IDX, 12'h206), pc_e + 4,
            1'b0);
        check("flags", 32'h9, {28'h0, flags});
        $display("test jump done");
        summarize();
    end

endmodule : lbx_exec_test

// *** test/lbx_imem.sv ***
/*
 * Instruction memory model that sits on the fetch side of the execution unit.
 * Assumes fetch_addr is a registered byte address and only the low 1 KB is used.
 */

`timescale 1ns/10ps

module lbx_imem
(
    // Fetch side
    input  wire logic [31:0] fetch_addr,
    output logic      [31:0] instr_word
);

    // Unwritten words hold never-executed patterns, so a stray fetch is harmless
    logic [31:0] mem [0:255];

    initial
    begin
        for (int i = 0; i < 256; i++)
            mem[i] = 32'hf0000000;
    end

    // Combinational fetch; upper address bits alias onto the 1 KB array
    assign instr_word = mem[fetch_addr[9:2]];

endmodule : lbx_imem

// *** verilog/lbx_exec.sv ***
/*
 * Execution unit for AND, bit clear, OR, move, status test-write, branch
 * and branch-with-link, with its own register file and program counter.
 * Assumes instructions arrive one per cycle on instr_valid from logic on the
 * same clock, in program order from fetch_addr, and that the host port is
 * driven synchronously to ref_clk.
 */

`timescale 1ns/10ps

module lbx_exec
    import lbx_pkg::*;
#(
    parameter logic [27:0] RESET_PC = 28'h0000000
)
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    // Instruction issue
    input  wire logic        instr_valid,
    input  wire logic [31:0] instr_word,
    // Host register port
    input  wire logic [4:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // Execution state
    output logic      [31:0] fetch_addr,
    output logic      [3:0]  flags,
    output logic             exec_done,
    output logic             redirect
);

    // The first word must be fetchable; refused while elaborating
    if (RESET_PC[1:0] != 2'b00)
    begin : g_bad_reset_pc
        $error("RESET_PC must be word aligned");
    end

    logic [31:0] regs [0:14];
    logic [27:0] pc;

    // Field decode
    wire [3:0] cond      = instr_word[COND_MSB:COND_LSB];
    wire [3:0] opc       = instr_word[24:21];
    wire       imm_op    = instr_word[IMM_BIT];
    wire       set_s     = instr_word[SETS_BIT];
    wire [3:0] rn_idx    = instr_word[19:16];
    wire [3:0] rd_idx    = instr_word[15:12];
    wire [3:0] rm_idx    = instr_word[3:0];
    wire [3:0] rs_idx    = instr_word[11:8];
    wire       reg_count = instr_word[REG_SHIFT_BIT];
    wire [4:0] imm_count = instr_word[11:7];
    wire [1:0] sh_kind   = instr_word[6:5];

    // PC as an executing instruction sees it, status nibble on top
    wire [27:0] pc_ahead = pc + PC_AHEAD;
    wire [31:0] pc_image = {flags, pc_ahead};
    wire [27:0] pc_next  = pc + PC_STEP;

    // Register reads; index 15 gives the status-carrying PC image
    wire [31:0] rn_val = (rn_idx == PC_IDX) ? pc_image : regs[rn_idx];
    wire [31:0] rm_val = (rm_idx == PC_IDX) ? pc_image : regs[rm_idx];
    wire [31:0] rs_val = (rs_idx == PC_IDX) ? pc_image : regs[rs_idx];

    // Condition evaluation
    logic cond_pass;
    always_comb
    begin
        unique case (cond)
            4'h0: cond_pass = flags[FLAG_Z];
            4'h1: cond_pass = !flags[FLAG_Z];
            4'h2: cond_pass = flags[FLAG_C];
            4'h3: cond_pass = !flags[FLAG_C];
            4'h4: cond_pass = flags[FLAG_N];
            4'h5: cond_pass = !flags[FLAG_N];
            4'h6: cond_pass = flags[FLAG_V];
            4'h7: cond_pass = !flags[FLAG_V];
            4'h8: cond_pass = flags[FLAG_C] && !flags[FLAG_Z];
            4'h9: cond_pass = !flags[FLAG_C] || flags[FLAG_Z];
            4'ha: cond_pass = flags[FLAG_N] == flags[FLAG_V];
            4'hb: cond_pass = flags[FLAG_N] != flags[FLAG_V];
            4'hc: cond_pass = !flags[FLAG_Z] && (flags[FLAG_N] == flags[FLAG_V]);
            4'hd: cond_pass = flags[FLAG_Z] || (flags[FLAG_N] != flags[FLAG_V]);
            COND_AL: cond_pass = 1'b1;
            COND_NV: cond_pass = 1'b0;
        endcase
    end

    // Class decode; multiply-space patterns are left alone
    wire is_dp   = (instr_word[27:26] == 2'b00) &&
                   !(!imm_op && instr_word[7] && instr_word[4]);
    wire is_br   = (instr_word[27:25] == 3'b101);
    wire run     = instr_valid && cond_pass;
    wire dp_run  = run && is_dp;
    wire br_run  = run && is_br;
    wire op_and  = (opc == OPC_AND);
    wire op_bic  = (opc == OPC_BIC);
    wire op_orr  = (opc == OPC_ORR);
    wire op_mov  = (opc == OPC_MOV);
    wire op_teq  = (opc == OPC_TEQ) && set_s;
    wire to_pc   = (rd_idx == PC_IDX);
    wire writes  = op_and || op_bic || op_orr || op_mov;
    wire teq_psr = op_teq && to_pc;

    // Immediate operand: 8 bits rotated right by twice the 4-bit field
    logic [31:0] imm_val;
    logic        imm_c;
    lbx_shifter u_imm_rot (
        .value     ({24'h0, instr_word[7:0]}),
        .amount    ({3'h0, rs_idx, 1'b0}),
        .kind      (LBX_ROR),
        .rotate_through_carry       (1'b0),
        .carry_in  (flags[FLAG_C]),
        .result    (imm_val),
        .carry_out (imm_c)
    );

    // Register operand; an immediate count of zero encodes 32 for right shifts or carry rotate for ROR
    wire       imm_zero = (imm_count == 5'h00);
    wire       sh_rrx   = !reg_count && imm_zero && (sh_kind == LBX_ROR);
    wire       sh_32    = !reg_count && imm_zero && sh_kind[0] ^ sh_kind[1];
    wire [7:0] sh_amt   = reg_count ? rs_val[7:0] :
                          sh_32 ? 8'h20 : {3'h0, imm_count};
    logic [31:0] sh_val;
    logic        sh_c;
    lbx_shifter u_reg_shift (
        .value     (rm_val),
        .amount    (sh_amt),
        .kind      (sh_kind),
        .rotate_through_carry       (sh_rrx),
        .carry_in  (flags[FLAG_C]),
        .result    (sh_val),
        .carry_out (sh_c)
    );

    wire [31:0] op2_val = imm_op ? imm_val : sh_val;
    wire        op2_c   = imm_op ? imm_c : sh_c;

    // Logic unit; no bit position feeds another
    wire [31:0] alu_result = op_and ? (rn_val & op2_val) :
                             op_bic ? (rn_val & ~op2_val) :
                             op_orr ? (rn_val | op2_val) :
                             op_mov ? op2_val : (rn_val ^ op2_val);
    // Mask operations take carry from both sign bits, others from the shifter
    wire        alu_c   = (op_and || op_bic) ?
                          (rn_val[31] & op2_val[31]) : op2_c;
    wire [3:0]  lg_flags = {alu_result[31], (alu_result == 32'h0), alu_c,
                            flags[FLAG_V]};

    // Branch target: word offset, sign-extended, added to the read-ahead PC
    wire [27:0] br_off    = {{2{instr_word[23]}}, instr_word[23:0], 2'b00};
    wire [27:0] br_target = pc_ahead + br_off;
    wire [27:0] jmp_addr  = {alu_result[27:2], 2'b00};

    // Next PC, flags and redirect
    wire dp_pc   = dp_run && writes && to_pc;
    wire [27:0] next_pc = br_run ? br_target : dp_pc ? jmp_addr : pc_next;
    logic [3:0] next_flags;
    always_comb
    begin
        next_flags = flags;
        if (dp_run && teq_psr)
            next_flags = alu_result[31:28];
        else if (dp_run && op_teq)
            next_flags = lg_flags;
        else if (dp_run && op_mov && to_pc && set_s)
            next_flags = alu_result[31:28];
        else if (dp_run && writes && !to_pc && set_s)
            next_flags = lg_flags;
        // Other logic writes to the PC leave status alone; branches never change it
    end

    // Host writes to the PC image or status override what the instruction did.
    // Without a host PC write the PC only moves on an issued instruction, so fetch_addr never drifts
    // ahead of the word that the fetch side is about to hand over.
    wire        host_pc          = reg_wr && (reg_addr == {1'b0, PC_IDX});
    wire        host_st          = reg_wr && (reg_addr == STATUS_ADDR);
    wire [27:0] next_pc_state    = host_pc ? {reg_wdata[27:2], 2'b00} :
                                   instr_valid ? next_pc : pc;
    wire [3:0]  next_flags_state = host_pc ? reg_wdata[31:28] :
                                   host_st ? reg_wdata[3:0] :
                                   instr_valid ? next_flags : flags;

    // Program counter and status; fetch_addr mirrors the same next value
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pc    <= RESET_PC;
            flags <= FLAGS_RST;
        end
        else
        begin
            pc    <= next_pc_state;
            flags <= next_flags_state;
        end
    end

    // Register file; a host write in the same cycle lands after the instruction
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            for (int i = 0; i < 15; i++)
                regs[i] <= REG_RST;
        end
        else
        begin
            if (br_run && instr_word[LINK_BIT])
                regs[LINK_IDX] <= {flags, pc_next};
            else if (dp_run && writes && !to_pc)
                regs[rd_idx] <= alu_result;
            if (reg_wr && !reg_addr[4] && reg_addr[3:0] != PC_IDX)
                regs[reg_addr[3:0]] <= reg_wdata;
        end
    end

    // Host read data, valid only in the cycle after the strobe
    wire [31:0] host_view = (reg_addr == STATUS_ADDR) ? {28'h0, flags} :
                            reg_addr[4] ? 32'h0 :
                            (reg_addr[3:0] == PC_IDX) ? {flags, pc} :
                            regs[reg_addr[3:0]];

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            reg_rdata  <= 32'h0;
            fetch_addr <= {4'h0, RESET_PC};
            exec_done  <= 1'b0;
            redirect   <= 1'b0;
        end
        else
        begin
            reg_rdata  <= reg_rd ? host_view : 32'h0;
            fetch_addr <= {4'h0, next_pc_state};
            exec_done  <= instr_valid;
            redirect   <= br_run || dp_pc;
        end
    end

    // Checks on the datapath
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    wire quiet = !reg_wr;

    and_write_a: assert property (
        dp_run && op_and && !to_pc && quiet |=>
            regs[$past(rd_idx)] == ($past(rn_val) & $past(op2_val)))
        else $error("AND result not written");

    imm_rotate_a: assert property (
        imm_op |-> op2_val == (({24'h0, instr_word[7:0]} >> {rs_idx, 1'b0}) |
                               ({24'h0, instr_word[7:0]} << (6'd32 - {rs_idx, 1'b0}))))
        else $error("immediate rotate wrong");

    mask_carry_a: assert property (
        dp_run && (op_and || op_bic) && set_s && !to_pc && quiet |=>
            flags[FLAG_C] == ($past(rn_val[31]) & $past(op2_val[31])))
        else $error("mask carry wrong");

    keep_v_a: assert property (
        dp_run && writes && !to_pc && quiet |=> $stable(flags[FLAG_V]))
        else $error("overflow flag changed");

    bic_write_a: assert property (
        dp_run && op_bic && !to_pc && quiet |=>
            regs[$past(rd_idx)] == ($past(rn_val) & ~$past(op2_val)))
        else $error("bit clear result wrong");

    status_guard_a: assert property (
        dp_run && (op_and || op_bic || op_orr) && to_pc && quiet |=> $stable(flags))
        else $error("status changed by logic op");

    branch_jump_a: assert property (
        br_run && quiet |=> pc == $past(pc) + 28'h8 +
            {{2{$past(instr_word[23])}}, $past(instr_word[23:0]), 2'b00} ##0 redirect)
        else $error("branch target wrong");

    link_save_a: assert property (
        br_run && instr_word[LINK_BIT] && quiet |=>
            regs[LINK_IDX][27:0] == $past(pc) + 28'h4)
        else $error("link address wrong");

    branch_flags_a: assert property (
        br_run && quiet |=> $stable(flags))
        else $error("branch changed flags");

    never_run_a: assert property (
        instr_valid && cond == COND_NV && quiet |=>
            pc == $past(pc) + 28'h4 && $stable(flags) && !redirect)
        else $error("never-condition executed");

    // Jumps by move, skipped instructions, the status write op, long shifts
    abs_jump_a: assert property (
        dp_run && op_mov && to_pc && quiet |=>
            pc == {$past(op2_val[27:2]), 2'b00} && redirect)
        else $error("absolute jump target wrong");

    move_keep_a: assert property (
        dp_run && op_mov && to_pc && !set_s && quiet |=> $stable(flags))
        else $error("plain move changed status");

    skip_false_a: assert property (
        instr_valid && !cond_pass && quiet |=>
            pc == $past(pc) + 28'h4 && $stable(flags) && !redirect)
        else $error("failed condition had effect");

    teq_status_a: assert property (
        dp_run && teq_psr && quiet |=>
            flags == ($past(rn_val[31:28]) ^ $past(op2_val[31:28])))
        else $error("status write op wrong");

    reg_count_a: assert property (
        dp_run && !imm_op && reg_count && rs_val[7:0] == 8'h20 &&
            sh_kind == LBX_SHR |-> sh_val == 32'h0)
        else $error("register shift of 32 wrong");

endmodule : lbx_exec

// *** verilog/lbx_shifter.sv ***
/*
 * Shared constants for the logic-and-branch execution unit, plus the barrel
 * shifter that forms the second operand.
 * Assumes a single synchronous clock domain; the shifter is purely combinational.
 */

`timescale 1ns/10ps

package lbx_pkg;

    // Instruction fields
    localparam int COND_MSB      = 31;
    localparam int COND_LSB      = 28;
    localparam int IMM_BIT       = 25;
    localparam int LINK_BIT      = 24;
    localparam int SETS_BIT      = 20;
    localparam int REG_SHIFT_BIT = 4;

    // Data-processing opcodes handled here
    localparam logic [3:0] OPC_AND = 4'h0;
    localparam logic [3:0] OPC_TEQ = 4'h9;
    localparam logic [3:0] OPC_ORR = 4'hc;
    localparam logic [3:0] OPC_MOV = 4'hd;
    localparam logic [3:0] OPC_BIC = 4'he;

    // Condition codes
    localparam logic [3:0] COND_AL = 4'he;
    localparam logic [3:0] COND_NV = 4'hf;

    // Register indices and host-port map
    localparam logic [3:0] LINK_IDX    = 4'he;
    localparam logic [3:0] PC_IDX      = 4'hf;
    localparam logic [4:0] STATUS_ADDR = 5'h10;

    // Flag positions inside the 4-bit status nibble {n,z,c,v}
    localparam int FLAG_N = 3;
    localparam int FLAG_Z = 2;
    localparam int FLAG_C = 1;
    localparam int FLAG_V = 0;

    // Program counter layout: status in the top nibble, address below
    localparam int          PC_W       = 28;
    localparam logic [27:0] PC_AHEAD   = 28'h0000008;
    localparam logic [27:0] PC_STEP    = 28'h0000004;
    localparam logic [3:0]  FLAGS_RST  = 4'h0;
    localparam logic [31:0] REG_RST    = 32'h00000000;

    typedef enum logic [1:0] {
        LBX_SHL = 2'b00,
        LBX_SHR = 2'b01,
        LBX_ASR = 2'b10,
        LBX_ROR = 2'b11
    } lbx_shift_t;

endpackage : lbx_pkg

module lbx_shifter
    import lbx_pkg::*;
(
    // Operand and control
    input  wire logic [31:0] value,
    input  wire logic [7:0]  amount,
    input  wire logic [1:0]  kind,
    input  wire logic        rotate_through_carry,
    input  wire logic        carry_in,
    // Result
    output logic      [31:0] result,
    output logic             carry_out
);

    logic        big;
    logic [5:0]  amt6;
    logic [4:0]  rot;
    logic [63:0] shl_w;
    logic [63:0] shr_w;
    logic [63:0] asr_w;
    logic [31:0] ror_v;

    // Shift counts of 64 and above saturate, rotates use only the low 5 bits; the wide forms give carry for free
    assign big   = |amount[7:6];
    assign amt6  = big ? 6'h3f : amount[5:0];
    assign rot   = amount[4:0];
    assign shl_w = {32'h0, value} << amt6;
    assign shr_w = {value, 32'h0} >> amt6;
    assign asr_w = 64'($signed({value, 32'h0}) >>> amt6);
    assign ror_v = (value >> rot) | (value << (6'd32 - {1'b0, rot}));

    always_comb
    begin
        result    = value;
        carry_out = carry_in;
        if (rotate_through_carry)
        begin
            result    = {carry_in, value[31:1]};
            carry_out = value[0];
        end
        else if (amount != 8'h00)
        begin
            unique case (kind)
                LBX_SHL:
                begin
                    result    = big ? 32'h0 : shl_w[31:0];
                    carry_out = big ? 1'b0 : shl_w[32];
                end
                LBX_SHR:
                begin
                    result    = big ? 32'h0 : shr_w[63:32];
                    carry_out = big ? 1'b0 : shr_w[31];
                end
                LBX_ASR:
                begin
                    result    = asr_w[63:32];
                    carry_out = asr_w[31];
                end
                LBX_ROR:
                begin
                    result    = ror_v;
                    carry_out = ror_v[31];
                end
            endcase
        end
    end

endmodule : lbx_shifter
